// *** chan_map_pkg.sv ***
// Constants for the channel input select register bank and its sequencer
package chan_map_pkg;

	// ****************************************************************
	// Register map (printed offsets are indices; byte address = 4 * index)
	// ****************************************************************
	localparam int unsigned NUM_CHANNELS     = 16;
	localparam logic [9:0]  MAP_FIRST_INDEX  = 10'h082;
	localparam logic [9:0]  MAP_LAST_INDEX   = 10'h0be;
	localparam logic [9:0]  MAP_INDEX_STEP   = 10'h004;
	localparam logic [9:0]  ENABLE_INDEX     = 10'h001;
	localparam logic [9:0]  STATUS_INDEX     = 10'h002;

	// ****************************************************************
	// Field layout of a channel input select register
	// ****************************************************************
	localparam int unsigned POS_LSB          = 8;
	localparam int unsigned POS_MSB          = 12;
	localparam int unsigned NEG_LSB          = 0;
	localparam int unsigned NEG_MSB          = 4;
	localparam logic [4:0]  POS_RESET        = 5'h00;
	localparam logic [4:0]  NEG_RESET        = 5'h01;
	localparam logic [15:0] ENABLE_RESET     = 16'h0001;

	// ****************************************************************
	// Sequencer states, Gray coded along idle, convert, advance
	// ****************************************************************
	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_CONVERT = 2'b01,
		SEQ_ADVANCE = 2'b11
	} seq_state_e;

endpackage

// *** chan_map_regs.sv ***
// Channel input select register bank with APB slave and channel sequencer
// Operation
// R01: Sixteen 16-bit select registers, index 0x82 step 4, each reset to 0x0001.
// R02: Each register picks the positive and negative mux inputs for its channel.
// R03: Any write to a select register resets filter, control logic and sequencer.
// R04: Positive code in bits 12:8 resets to zero; shared code table.
// R05: Negative code in bits 4:0 resets to one; same code table.
// R06: Reserved bits read zero and ignore writes; reserved codes not programmed.
// R07: Enabled channels convert in turn, each with its own input pair.
`timescale 1ns/1ps

module chan_map_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        conversion_done,
	output logic      [4:0]  positive_mux_input,
	output logic      [4:0]  negative_mux_input,
	output logic      [3:0]  active_channel,
	output logic             sequencer_active,
	output logic             filter_reset
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Decode a byte address into a channel number, with a hit flag
	function automatic logic [4:0] map_decode(input logic [11:0] addr);
		logic [9:0] idx;
		logic [9:0] off;
		idx = addr[11:2];
		off = idx - chan_map_pkg::MAP_FIRST_INDEX;
		map_decode = 5'h00;
		if (addr[1:0] == 2'h0 && idx >= chan_map_pkg::MAP_FIRST_INDEX &&
			idx <= chan_map_pkg::MAP_LAST_INDEX && off[1:0] == 2'h0) begin
			map_decode = {1'b1, off[5:2]};
		end
	endfunction

	// Next enabled channel after cur, wrapping round
	function automatic logic [3:0] next_enabled(input logic [15:0] en, input logic [3:0] cur);
		logic [3:0] cand;
		logic       found;
		next_enabled = cur;
		found = 1'b0;
		for (int k = 1; k <= 16; k++) begin
			cand = cur + 4'(k);
			if (!found && en[cand]) begin
				next_enabled = cand;
				found = 1'b1;
			end
		end
	endfunction

	// Match a byte address against one word index of the register map
	function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] index);
		reg_hit = addr == {index, 2'h0};
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [15:0][4:0]         pos;
		logic [15:0][4:0]         neg;
		logic [15:0]              enable;
		chan_map_pkg::seq_state_e state;
		logic [3:0]               chan;
		logic [4:0]               pos_out;
		logic [4:0]               neg_out;
		logic                     frst;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
		logic                     active;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic [4:0]  dec;
	logic        acc;
	logic        done_xfer;
	logic        map_wr;
	logic        en_wr;

	// Bus decode
	assign dec       = map_decode(paddr);
	assign acc       = psel & penable;
	assign done_xfer = acc & s_q.pready;
	assign map_wr    = done_xfer & pwrite & dec[4];
	assign en_wr     = done_xfer & pwrite & reg_hit(paddr, chan_map_pkg::ENABLE_INDEX);

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Bus slave, register writes and sequencer
	always_comb begin
		s_d = s_q;
		s_d.frst = 1'b0;
		// One wait cycle: answer on the second access cycle
		if (acc && !s_q.pready) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = 1'b0;
			s_d.prdata  = 32'h0000_0000; // R06
			if (dec[4]) begin
				s_d.prdata[chan_map_pkg::POS_MSB:chan_map_pkg::POS_LSB] = s_q.pos[dec[3:0]]; // R04
				s_d.prdata[chan_map_pkg::NEG_MSB:chan_map_pkg::NEG_LSB] = s_q.neg[dec[3:0]]; // R05
			end else if (reg_hit(paddr, chan_map_pkg::ENABLE_INDEX)) begin
				s_d.prdata[15:0] = s_q.enable;
			end else if (reg_hit(paddr, chan_map_pkg::STATUS_INDEX)) begin
				s_d.prdata[6:0] = {s_q.state != chan_map_pkg::SEQ_IDLE, s_q.state, s_q.chan};
			end else begin
				s_d.pslverr = 1'b1;
			end
		end else if (done_xfer) begin
			s_d.pready  = 1'b0;
			s_d.pslverr = 1'b0;
		end
		// Sequencer stepping through enabled channels
		unique case (s_q.state)
			chan_map_pkg::SEQ_IDLE: begin
				if (s_q.enable != 16'h0000) begin
					s_d.chan    = next_enabled(s_q.enable, 4'hf); // R07
					s_d.pos_out = s_q.pos[s_d.chan]; // R02
					s_d.neg_out = s_q.neg[s_d.chan]; // R02
					s_d.state   = chan_map_pkg::SEQ_CONVERT;
				end
			end
			chan_map_pkg::SEQ_CONVERT: begin
				if (conversion_done) begin
					s_d.state = chan_map_pkg::SEQ_ADVANCE;
				end
			end
			chan_map_pkg::SEQ_ADVANCE: begin
				s_d.chan    = next_enabled(s_q.enable, s_q.chan); // R07
				s_d.pos_out = s_q.pos[s_d.chan]; // R02
				s_d.neg_out = s_q.neg[s_d.chan]; // R02
				s_d.state   = chan_map_pkg::SEQ_CONVERT;
			end
			default: begin
				s_d.state = chan_map_pkg::SEQ_IDLE;
			end
		endcase
		// Register writes; reserved bits are simply not stored
		if (map_wr) begin
			s_d.pos[dec[3:0]] = pwdata[chan_map_pkg::POS_MSB:chan_map_pkg::POS_LSB]; // R04
			s_d.neg[dec[3:0]] = pwdata[chan_map_pkg::NEG_MSB:chan_map_pkg::NEG_LSB]; // R05
		end
		if (en_wr) begin
			s_d.enable = pwdata[15:0];
		end
		// A select or enable write restarts filter, control and sequence
		if (map_wr || en_wr) begin
			s_d.frst  = 1'b1; // R03
			s_d.state = chan_map_pkg::SEQ_IDLE; // R03
			s_d.chan  = 4'h0;
		end
		// Busy flag kept in a flop beside the state it mirrors
		s_d.active = s_d.state != chan_map_pkg::SEQ_IDLE; // R07
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// State register with reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) begin
				s_q.pos[i] <= chan_map_pkg::POS_RESET; // R01
				s_q.neg[i] <= chan_map_pkg::NEG_RESET; // R01
			end
			s_q.enable  <= chan_map_pkg::ENABLE_RESET;
			s_q.state   <= chan_map_pkg::SEQ_IDLE;
			s_q.chan    <= 4'h0;
			s_q.pos_out <= chan_map_pkg::POS_RESET;
			s_q.neg_out <= chan_map_pkg::NEG_RESET;
			s_q.frst    <= 1'b0;
			s_q.pready  <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.prdata  <= 32'h0000_0000;
			s_q.active  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign prdata             = s_q.prdata;
	assign pready             = s_q.pready;
	assign pslverr            = s_q.pslverr;
	assign positive_mux_input = s_q.pos_out;
	assign negative_mux_input = s_q.neg_out;
	assign active_channel     = s_q.chan;
	assign sequencer_active   = s_q.active;
	assign filter_reset       = s_q.frst;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	// Helper: map write data of the completing transfer
	logic [4:0] wr_pos;
	logic [4:0] wr_neg;
	assign wr_pos = pwdata[chan_map_pkg::POS_MSB:chan_map_pkg::POS_LSB];
	assign wr_neg = pwdata[chan_map_pkg::NEG_MSB:chan_map_pkg::NEG_LSB];

	AST_WRITE_STORES: assert property (@(posedge pclk) disable iff (!presetn) // R01
		map_wr |=> s_q.pos[$past(dec[3:0])] == $past(wr_pos) &&
		s_q.neg[$past(dec[3:0])] == $past(wr_neg))
		else $error("Select register did not take written value");

	AST_POS_DRIVES_MUX: assert property (@(posedge pclk) disable iff (!presetn) // R02
		s_q.state == chan_map_pkg::SEQ_CONVERT |-> positive_mux_input == s_q.pos[s_q.chan])
		else $error("Positive mux input differs from active channel");

	AST_WRITE_RESETS: assert property (@(posedge pclk) disable iff (!presetn) // R03
		map_wr |=> filter_reset && !sequencer_active ##1 !filter_reset)
		else $error("Select write did not pulse filter reset");

	AST_POS_READBACK: assert property (@(posedge pclk) disable iff (!presetn) // R04
		acc && !pready && !pwrite && dec[4] |=> prdata[12:8] == s_q.pos[$past(dec[3:0])])
		else $error("Positive code readback wrong");

	AST_NEG_READBACK: assert property (@(posedge pclk) disable iff (!presetn) // R05
		acc && !pready && !pwrite && dec[4] |=> prdata[4:0] == s_q.neg[$past(dec[3:0])])
		else $error("Negative code readback wrong");

	AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R06
		pready && !pslverr && $past(dec[4]) |-> prdata[31:13] == 19'h0 && prdata[7:5] == 3'h0)
		else $error("Reserved bits read nonzero");

	AST_CHANNEL_ENABLED: assert property (@(posedge pclk) disable iff (!presetn) // R07
		sequencer_active |-> s_q.enable[active_channel])
		else $error("Sequencer sits on a disabled channel");

	AST_ADVANCE_BOUNDED: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.state == chan_map_pkg::SEQ_CONVERT && conversion_done && !map_wr && !en_wr
		|=> ##1 s_q.state == chan_map_pkg::SEQ_CONVERT || !sequencer_active)
		else $error("Sequencer did not move to next channel");

	// ****************************************************************
	// Bus handshake and decode assertions
	// ****************************************************************

	AST_ONE_WAIT_STATE: assert property (@(posedge pclk) disable iff (!presetn) // R01
		acc && !pready |=> pready)
		else $error("Slave did not answer after one wait state");

	AST_READY_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn) // R01
		pready |=> !pready)
		else $error("Ready stood longer than one cycle");

	AST_READY_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn) // R01
		pready |-> $past(acc))
		else $error("Ready raised outside an access phase");

	AST_MAPPED_NO_ERROR: assert property (@(posedge pclk) disable iff (!presetn) // R01
		acc && !pready && dec[4] |=> !pslverr)
		else $error("Select register access flagged as error");

	AST_UNMAPPED_ERROR: assert property (@(posedge pclk) disable iff (!presetn) // R01
		acc && !pready && !dec[4] && !reg_hit(paddr, chan_map_pkg::ENABLE_INDEX) &&
		!reg_hit(paddr, chan_map_pkg::STATUS_INDEX) |=> pslverr && prdata == 32'h0000_0000)
		else $error("Unmapped access not refused");

	AST_OTHER_WRITE_KEEPS: assert property (@(posedge pclk) disable iff (!presetn) // R01
		done_xfer && !map_wr |=> $stable(s_q.pos) && $stable(s_q.neg))
		else $error("Select codes changed without a select write");

	AST_ENABLE_READBACK: assert property (@(posedge pclk) disable iff (!presetn) // R07
		acc && !pready && !pwrite && reg_hit(paddr, chan_map_pkg::ENABLE_INDEX)
		|=> prdata == {16'h0000, $past(s_q.enable)})
		else $error("Enable readback wrong");

	AST_STATUS_READBACK: assert property (@(posedge pclk) disable iff (!presetn) // R07
		acc && !pready && !pwrite && reg_hit(paddr, chan_map_pkg::STATUS_INDEX)
		|=> prdata[6] == $past(sequencer_active) && prdata[3:0] == $past(active_channel))
		else $error("Status readback wrong");

	// ****************************************************************
	// Restart and sequencer assertions
	// ****************************************************************

	AST_NEG_DRIVES_MUX: assert property (@(posedge pclk) disable iff (!presetn) // R02
		s_q.state == chan_map_pkg::SEQ_CONVERT |-> negative_mux_input == s_q.neg[s_q.chan])
		else $error("Negative mux input differs from active channel");

	AST_ENABLE_WRITE_RESETS: assert property (@(posedge pclk) disable iff (!presetn) // R03
		en_wr |=> filter_reset && !sequencer_active)
		else $error("Enable write did not restart the sequencer");

	AST_PULSE_ONLY_ON_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R03
		!map_wr && !en_wr |=> !filter_reset)
		else $error("Filter reset pulsed without a write");

	AST_REWIND_CHANNEL: assert property (@(posedge pclk) disable iff (!presetn) // R03
		map_wr |=> active_channel == 4'h0)
		else $error("Select write did not rewind the channel");

	AST_MUX_HOLDS: assert property (@(posedge pclk) disable iff (!presetn) // R02
		s_q.state == chan_map_pkg::SEQ_CONVERT &&
		$past(s_q.state) == chan_map_pkg::SEQ_CONVERT |->
		$stable(positive_mux_input) && $stable(negative_mux_input))
		else $error("Mux inputs changed during a conversion");

	AST_CHANNEL_HOLDS: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.state == chan_map_pkg::SEQ_CONVERT &&
		$past(s_q.state) == chan_map_pkg::SEQ_CONVERT |-> $stable(active_channel))
		else $error("Channel changed during a conversion");

	AST_CONVERT_WAITS: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.state == chan_map_pkg::SEQ_CONVERT && !conversion_done && !map_wr && !en_wr
		|=> s_q.state == chan_map_pkg::SEQ_CONVERT)
		else $error("Conversion left without done");

	AST_ADVANCE_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.state == chan_map_pkg::SEQ_ADVANCE && !map_wr && !en_wr
		|=> s_q.state == chan_map_pkg::SEQ_CONVERT)
		else $error("Advance step lasted more than one cycle");

	AST_IDLE_STARTS: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.state == chan_map_pkg::SEQ_IDLE && s_q.enable != 16'h0000 && !map_wr && !en_wr
		|=> sequencer_active)
		else $error("Sequencer did not start with channels enabled");

	AST_FIRST_IS_LOWEST: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.state == chan_map_pkg::SEQ_IDLE && s_q.enable[0] && !map_wr && !en_wr
		|=> active_channel == 4'h0)
		else $error("Sequence did not start at channel zero");

	AST_NONE_ENABLED_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // R07
		s_q.enable == 16'h0000 |-> !sequencer_active)
		else $error("Sequencer active with no channel enabled");

endmodule

// *** tb.sv ***
// Self-checking testbench for the channel input select register bank
`timescale 1ns/1ps

module tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        conversion_done;
	logic [4:0]  positive_mux_input;
	logic [4:0]  negative_mux_input;
	logic [3:0]  active_channel;
	logic        sequencer_active;
	logic        filter_reset;
	int          n_fail;
	int          cmp_count;
	int          seed;
	int          cycles;
	logic [31:0] rd;
	logic        err;
	logic [15:0] shadow [16];

	chan_map_regs chan_map_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conversion_done(conversion_done),
		.positive_mux_input(positive_mux_input), .negative_mux_input(negative_mux_input),
		.active_channel(active_channel), .sequencer_active(sequencer_active),
		.filter_reset(filter_reset));

	// ****************************************************************
	// Clock, hang guard and shared tasks
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Cut a hung run short well beyond the expected length
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Byte address of a select register: four times its word index
	function automatic logic [11:0] sel_addr(input int ch);
		return 12'(4 * (32'h82 + 4 * ch));
	endfunction

	// Swap a reserved input code for an external input, as software must
	function automatic logic [4:0] legal_code(input logic [4:0] c);
		if ((c > 5'h08 && c < 5'h11) || c == 5'h14 || c > 5'h1d) begin
			return 5'(c % 5'h09);
		end
		return c;
	endfunction

	// Random word with both input codes kept legal, reserved bits left random
	function automatic logic [31:0] legal_word(input logic [31:0] r);
		return {r[31:13], legal_code(r[12:8]), r[7:5], legal_code(r[4:0])};
	endfunction

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// Write a select register, expect the restart pulse, track stored bits
	task automatic wr_sel(input int ch, input logic [31:0] d);
		apb(1'b1, sel_addr(ch), d);
		check({31'h0, filter_reset}, 32'h1);
		shadow[ch] = d[15:0] & 16'h1f1f;
	endtask

	task automatic seq_check(input int ch);
		check({28'h0, active_channel}, 32'(ch));
		check({27'h0, positive_mux_input}, {27'h0, shadow[ch][12:8]});
		check({27'h0, negative_mux_input}, {27'h0, shadow[ch][4:0]});
	endtask

	task automatic pulse_done();
		@(posedge pclk);
		conversion_done <= 1'b1;
		@(posedge pclk);
		conversion_done <= 1'b0;
		@(posedge pclk);
		#1;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 32227;
		n_fail = 0;
		cmp_count = 0;
		cycles = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		conversion_done = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check({27'h0, positive_mux_input}, 32'h0);
		check({27'h0, negative_mux_input}, 32'h1);
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, sel_addr(i), 32'h0);
			check(rd, 32'h0000_0001);
			shadow[i] = 16'h0001;
		end
		$display("reset value test done");
		// Reserved bits all set with top legal codes first, then random legal words
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 16; i++) begin
				wr_sel(i, (k == 0) ? 32'hffff_fdfd : legal_word($random(seed)));
			end
			for (int i = 0; i < 16; i++) begin
				apb(1'b0, sel_addr(i), 32'h0);
				check(rd, {16'h0, shadow[i]});
			end
		end
		$display("write and read back test done");
		// Unmapped places answer with an error and hold no data
		apb(1'b1, 12'h204, 32'hffff_ffff);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		apb(1'b0, sel_addr(0), 32'h0);
		check(rd, {16'h0, shadow[0]});
		$display("unmapped address test done");
		// Channels 0 and 1 take turns; a select write restarts at channel 0
		apb(1'b1, 12'h004, 32'h0000_0003);
		repeat (3) @(posedge pclk);
		#1;
		check({31'h0, sequencer_active}, 32'h1);
		seq_check(0);
		// Status shows active, converting, channel 0; enable reads back
		apb(1'b0, 12'h008, 32'h0);
		check(rd, 32'h0000_0050);
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0000_0003);
		pulse_done();
		seq_check(1);
		wr_sel(5, legal_word($random(seed)));
		repeat (3) @(posedge pclk);
		#1;
		seq_check(0);
		pulse_done();
		seq_check(1);
		pulse_done();
		seq_check(0);
		// No channel enabled keeps the sequencer idle
		apb(1'b1, 12'h004, 32'h0);
		pulse_done();
		check({31'h0, sequencer_active}, 32'h0);
		$display("sequencer test done");
		// A reset in mid-run brings every register back to its default
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check({27'h0, positive_mux_input}, 32'h0);
		check({27'h0, negative_mux_input}, 32'h1);
		check({31'h0, sequencer_active}, 32'h0);
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, sel_addr(i), 32'h0);
			check(rd, 32'h0000_0001);
		end
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0000_0001);
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule
